// >>> inc/pmesw_map.svh
/*
  Register indices, field positions and reset values of the power
  management event, status and wake block.
  Assumes inclusion by its bare name from the design files.
*/
`ifndef PMESW_MAP_SVH
`define PMESW_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define PMESW_IDX_DEEP_SLEEP   6'h15
`define PMESW_IDX_EVT_STATUS   6'h20
`define PMESW_IDX_SCI_MASK     6'h22
`define PMESW_IDX_SMI_MASK     6'h24
`define PMESW_IDX_WAKE_CTL     6'h26
`define PMESW_IDX_AUX_STATUS   6'h30
`define PMESW_IDX_IRQ_STATUS   6'h31
`define PMESW_IDX_IRQ_MASK     6'h32

// ****************************************************************
// Fields
// ****************************************************************
`define PMESW_EVT_W            10
`define PMESW_EVT_USB          9
`define PMESW_EVT_RING         8
`define PMESW_EXT_W            8
`define PMESW_WCTL_RING        10
`define PMESW_WCTL_BUTTON      9
`define PMESW_WCTL_ALARM       8
`define PMESW_WCTL_EXT0        0
`define PMESW_WCTL_MASK        16'h0701
`define PMESW_AUX_BUTTON       0
`define PMESW_AUX_ALARM        1
`define PMESW_AUX_STOPPED      8
`define PMESW_IRQ_W            3
`define PMESW_IRQ_EVENT        0
`define PMESW_IRQ_SLEEP        1
`define PMESW_IRQ_POWER        2

// ****************************************************************
// Reset values
// ****************************************************************
`define PMESW_RST_EVT          10'h000
`define PMESW_RST_REG16        16'h0000
`define PMESW_RST_IRQ          3'h0
`define PMESW_RST_DATA         32'h0000_0000
`define PMESW_RST_EXT          8'hFF

`endif

// >>> inc/pmesw_pkg.sv
/*
  Types of the power management event, status and wake block.
  Assumes the map header supplies widths; nothing here is imported.
*/
`include "pmesw_map.svh"

package pmesw_pkg;

  // ****************************************************************
  // Processor clock state
  // ****************************************************************
  typedef enum logic [0:0] {
    PMESW_RUN  = 1'b0,
    PMESW_STOP = 1'b1
  } pmesw_cpu_state_t;

  // ****************************************************************
  // Synchronised pin levels, active high
  // ****************************************************************
  typedef struct packed {
    logic [`PMESW_EXT_W-1:0] ext_level;
    logic                    ring_active;
    logic                    button_active;
  } pmesw_pins_t;

  // ****************************************************************
  // Hardware set requests for the sticky flags
  // ****************************************************************
  typedef struct packed {
    logic [`PMESW_EVT_W-1:0] evt;
    logic                    button;
    logic                    alarm;
  } pmesw_set_t;

endpackage

// >>> design/pmesw_top.sv
/*
  Power management event logic: sticky event flags, SCI and SMI masks,
  wake power control, deep sleep entry port and an APB register slave.
  Assumes one 50 MHz clock, a synchronous active high reset and pins
  that are asynchronous to it, yet only the event pin, ring and button levels are synchronised; USB resume and RTC alarm are used directly.
*/
`timescale 1ns/100ps
`include "pmesw_map.svh"

module pmesw_top (
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  input  wire logic        psel_in,
  input  wire logic        penable_in,
  input  wire logic        pwrite_in,
  input  wire logic [7:0]  paddr_in,
  input  wire logic [31:0] pwdata_in,
  output logic      [31:0] prdata_out,
  output logic             pready_out,
  output logic             pslverr_out,
  input  wire logic        usb_resume_in,
  input  wire logic        ring_indicator_n_in,
  input  wire logic [7:0]  ext_event_pin_n_in,
  input  wire logic        power_button_n_in,
  input  wire logic        rtc_alarm_in,
  output logic             sci_out,
  output logic             smi_out,
  output logic             main_power_on_out,
  output logic             processor_clock_stop_n_out,
  output logic             irq_out
);

  // ****************************************************************
  // Functions
  // ****************************************************************
  function automatic logic [7:0] reg_addr(input logic [5:0] idx);
    reg_addr = {idx, 2'h0};
  endfunction

  function automatic logic [31:0] zext16(input logic [15:0] val);
    zext16 = {16'h0000, val};
  endfunction

  // ****************************************************************
  // Storage
  // ****************************************************************
  pmesw_pkg::pmesw_pins_t      meta_ff;
  pmesw_pkg::pmesw_pins_t      sync_ff;
  logic [`PMESW_EXT_W-1:0]     ext_prev_ff;
  logic [`PMESW_EVT_W-1:0]     evt_status_ff;
  logic [`PMESW_EVT_W-1:0]     sci_mask_ff;
  logic [`PMESW_EVT_W-1:0]     smi_mask_ff;
  logic [15:0]                 wake_ctl_ff;
  logic                        button_flag_ff;
  logic                        alarm_flag_ff;
  logic [`PMESW_IRQ_W-1:0]     irq_status_ff;
  logic [`PMESW_IRQ_W-1:0]     irq_mask_ff;
  pmesw_pkg::pmesw_cpu_state_t cpu_state_ff;
  logic [31:0]                 prdata_ff;
  logic                        pready_ff;
  logic                        pslverr_ff;
  logic                        sci_ff;
  logic                        smi_ff;
  logic                        power_on_ff;
  logic                        irq_ff;
  logic                        stop_n_ff;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  // Pins are active low; invert before the first stage
  wire pmesw_pkg::pmesw_pins_t pins_raw = '{
    ext_level:     ~ext_event_pin_n_in,
    ring_active:   ~ring_indicator_n_in,
    button_active: ~power_button_n_in
  };

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      meta_ff     <= '0;
      sync_ff     <= '0;
      ext_prev_ff <= ~`PMESW_RST_EXT;
    end else begin
      meta_ff     <= pins_raw;
      sync_ff     <= meta_ff;
      ext_prev_ff <= sync_ff.ext_level;
    end
  end

  // ****************************************************************
  // APB decode
  // ****************************************************************
  // One wait state: data and error are registered with pready
  wire        bus_access = psel_in & penable_in & ~pready_ff;
  wire        bus_done   = psel_in & penable_in & pready_ff;
  wire        wr_done    = bus_done & pwrite_in;
  wire        rd_done    = bus_done & ~pwrite_in;
  wire        hit_sleep  = paddr_in == reg_addr(`PMESW_IDX_DEEP_SLEEP);
  wire        hit_evt    = paddr_in == reg_addr(`PMESW_IDX_EVT_STATUS);
  wire        hit_sci    = paddr_in == reg_addr(`PMESW_IDX_SCI_MASK);
  wire        hit_smi    = paddr_in == reg_addr(`PMESW_IDX_SMI_MASK);
  wire        hit_wake   = paddr_in == reg_addr(`PMESW_IDX_WAKE_CTL);
  wire        hit_aux    = paddr_in == reg_addr(`PMESW_IDX_AUX_STATUS);
  wire        hit_irqs   = paddr_in == reg_addr(`PMESW_IDX_IRQ_STATUS);
  wire        hit_irqm   = paddr_in == reg_addr(`PMESW_IDX_IRQ_MASK);
  wire        hit_any    = hit_sleep | hit_evt | hit_sci | hit_smi | hit_wake
                           | hit_aux | hit_irqs | hit_irqm;
  wire [31:0] aux_value  = zext16({7'h00, cpu_state_ff == pmesw_pkg::PMESW_STOP,
                                   6'h00, alarm_flag_ff, button_flag_ff});

  // ****************************************************************
  // Register strobes
  // ****************************************************************
  // Strobes fire only on the completing edge of a transfer
  wire        wr_evt     = wr_done & hit_evt;
  wire        wr_aux     = wr_done & hit_aux;
  wire        wr_sci     = wr_done & hit_sci;
  wire        wr_smi     = wr_done & hit_smi;
  wire        wr_wake    = wr_done & hit_wake;
  wire        wr_irqm    = wr_done & hit_irqm;
  wire        rd_irqs    = rd_done & hit_irqs;

  // Deep sleep port falls to the default arm and reads zero
  logic [31:0] rd_value;
  always_comb begin
    rd_value = `PMESW_RST_DATA;
    if (hit_evt) begin
      rd_value = zext16({6'h00, evt_status_ff});
    end
    if (hit_sci) begin
      rd_value = zext16({6'h00, sci_mask_ff});
    end
    if (hit_smi) begin
      rd_value = zext16({6'h00, smi_mask_ff});
    end
    if (hit_wake) begin
      rd_value = zext16(wake_ctl_ff);
    end
    if (hit_aux) begin
      rd_value = aux_value;
    end
    if (hit_irqs) begin
      rd_value = {29'h0, irq_status_ff};
    end
    if (hit_irqm) begin
      rd_value = {29'h0, irq_mask_ff};
    end
  end

  // ****************************************************************
  // Event sources
  // ****************************************************************
  wire pmesw_pkg::pmesw_set_t set_req = '{
    evt: {usb_resume_in,
          sync_ff.ring_active,
          sync_ff.ext_level ^ ext_prev_ff},
    button: sync_ff.button_active,
    alarm:  rtc_alarm_in
  };

  wire [`PMESW_EVT_W-1:0] evt_clr     = wr_evt ? pwdata_in[`PMESW_EVT_W-1:0] : '0;
  wire [1:0]              aux_clr     = wr_aux ? pwdata_in[1:0] : 2'h0;
  // Set wins over a same-cycle clear
  wire [`PMESW_EVT_W-1:0] nxt_evt     = (evt_status_ff & ~evt_clr) | set_req.evt;
  wire                    nxt_button  = (button_flag_ff & ~aux_clr[`PMESW_AUX_BUTTON])
                                        | set_req.button;
  wire                    nxt_alarm   = (alarm_flag_ff & ~aux_clr[`PMESW_AUX_ALARM])
                                        | set_req.alarm;
  wire                    new_evt     = |(set_req.evt & ~evt_status_ff);
  wire                    new_flag    = new_evt | (set_req.button & ~button_flag_ff)
                                        | (set_req.alarm & ~alarm_flag_ff);

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      evt_status_ff <= `PMESW_RST_EVT;
    end else begin
      evt_status_ff <= nxt_evt;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      button_flag_ff <= 1'h0;
    end else begin
      button_flag_ff <= nxt_button;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      alarm_flag_ff <= 1'h0;
    end else begin
      alarm_flag_ff <= nxt_alarm;
    end
  end

  // ****************************************************************
  // Masks and wake control
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sci_mask_ff <= `PMESW_RST_EVT;
    end else if (wr_sci) begin
      sci_mask_ff <= pwdata_in[`PMESW_EVT_W-1:0];
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      smi_mask_ff <= `PMESW_RST_EVT;
    end else if (wr_smi) begin
      smi_mask_ff <= pwdata_in[`PMESW_EVT_W-1:0];
    end
  end

  // Unused control bits are dropped so they always read zero
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      wake_ctl_ff <= `PMESW_RST_REG16;
    end else if (wr_wake) begin
      wake_ctl_ff <= pwdata_in[15:0] & `PMESW_WCTL_MASK;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_mask_ff <= `PMESW_RST_IRQ;
    end else if (wr_irqm) begin
      irq_mask_ff <= pwdata_in[`PMESW_IRQ_W-1:0];
    end
  end

  // ****************************************************************
  // SCI, SMI and main power on
  // ****************************************************************
  // Same bit position in both masks; level held while a flag stays set
  wire nxt_sci = |(nxt_evt & sci_mask_ff);
  wire nxt_smi = |(nxt_evt & smi_mask_ff);
  wire nxt_power_on =
    (nxt_evt[`PMESW_EVT_RING] & wake_ctl_ff[`PMESW_WCTL_RING])
    | (nxt_button & wake_ctl_ff[`PMESW_WCTL_BUTTON])
    | (nxt_alarm & wake_ctl_ff[`PMESW_WCTL_ALARM])
    | (nxt_evt[0] & wake_ctl_ff[`PMESW_WCTL_EXT0]);

  // ****************************************************************
  // Processor clock stop
  // ****************************************************************
  // A fresh flag wakes the processor; a pending entry read wins
  wire sleep_entry = rd_done & hit_sleep;
  pmesw_pkg::pmesw_cpu_state_t nxt_cpu_state;
  always_comb begin
    nxt_cpu_state = cpu_state_ff;
    unique case (cpu_state_ff)
      pmesw_pkg::PMESW_RUN: begin
        if (sleep_entry) begin
          nxt_cpu_state = pmesw_pkg::PMESW_STOP;
        end
      end
      pmesw_pkg::PMESW_STOP: begin
        if (new_flag & ~sleep_entry) begin
          nxt_cpu_state = pmesw_pkg::PMESW_RUN;
        end
      end
    endcase
  end

  // ****************************************************************
  // Block interrupt
  // ****************************************************************
  wire [`PMESW_IRQ_W-1:0] irq_set = {nxt_power_on & ~power_on_ff, sleep_entry, new_flag};
  wire [`PMESW_IRQ_W-1:0] irq_clr = rd_irqs ? {`PMESW_IRQ_W{1'h1}} : '0;
  wire [`PMESW_IRQ_W-1:0] nxt_irq_status = (irq_status_ff & ~irq_clr) | irq_set;

  // ****************************************************************
  // Output registers
  // ****************************************************************
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prdata_ff  <= `PMESW_RST_DATA;
      pready_ff  <= 1'h0;
      pslverr_ff <= 1'h0;
    end else begin
      prdata_ff  <= (bus_access & ~pwrite_in) ? rd_value : `PMESW_RST_DATA;
      pready_ff  <= bus_access;
      pslverr_ff <= bus_access & ~hit_any;
    end
  end

  // Pin flop follows the next state, so it turns with the state itself
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      cpu_state_ff <= pmesw_pkg::PMESW_RUN;
      stop_n_ff    <= 1'h1;
    end else begin
      cpu_state_ff <= nxt_cpu_state;
      stop_n_ff    <= nxt_cpu_state != pmesw_pkg::PMESW_STOP;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      irq_status_ff <= `PMESW_RST_IRQ;
      irq_ff        <= 1'h0;
    end else begin
      irq_status_ff <= nxt_irq_status;
      irq_ff        <= |(nxt_irq_status & irq_mask_ff);
    end
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sci_ff      <= 1'h0;
      smi_ff      <= 1'h0;
      power_on_ff <= 1'h0;
    end else begin
      sci_ff      <= nxt_sci;
      smi_ff      <= nxt_smi;
      power_on_ff <= nxt_power_on;
    end
  end

  assign prdata_out                 = prdata_ff;
  assign pready_out                 = pready_ff;
  assign pslverr_out                = pslverr_ff;
  assign sci_out                    = sci_ff;
  assign smi_out                    = smi_ff;
  assign main_power_on_out          = power_on_ff;
  assign irq_out                    = irq_ff;
  assign processor_clock_stop_n_out = stop_n_ff;

endmodule

// >>> verification/pmesw_sva.sv
/* Assertions for the event, status and wake block.
   Assumes it is bound to pmesw_top and sees its ports only. */
`timescale 1ns/100ps
module pmesw_sva (
  input wire logic        mclk_in,
  input wire logic        rst_in,
  input wire logic        psel_in,
  input wire logic        penable_in,
  input wire logic        pwrite_in,
  input wire logic [7:0]  paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic        pready_out,
  input wire logic        pslverr_out,
  input wire logic        usb_resume_in,
  input wire logic        ring_indicator_n_in,
  input wire logic [7:0]  ext_event_pin_n_in,
  input wire logic        power_button_n_in,
  input wire logic        rtc_alarm_in,
  input wire logic        sci_out,
  input wire logic        smi_out,
  input wire logic        main_power_on_out,
  input wire logic        processor_clock_stop_n_out
);
  // ****************************************************************
  // Mask shadows
  // ****************************************************************
  default clocking @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  logic [9:0]  sci_m_ff;
  logic [9:0]  smi_m_ff;
  logic [10:0] wctl_ff;
  wire         wr_done = psel_in & penable_in & pready_out & pwrite_in;
  // Shadows follow completed writes, so no internal state is needed
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      sci_m_ff <= 10'h000;
      smi_m_ff <= 10'h000;
      wctl_ff  <= 11'h000;
    end else if (wr_done) begin
      if (paddr_in == 8'h88) sci_m_ff <= pwdata_in[9:0];
      if (paddr_in == 8'h90) smi_m_ff <= pwdata_in[9:0];
      if (paddr_in == 8'h98) wctl_ff <= pwdata_in[10:0] & 11'h701;
    end
  end
  // ****************************************************************
  // Sequences and properties
  // ****************************************************************
  sequence s_sleep_read;
    psel_in && penable_in && pready_out && !pwrite_in && paddr_in == 8'h54;
  endsequence
  sequence s_ring_held;
    !ring_indicator_n_in [*4];
  endsequence
  sequence s_button_held;
    !power_button_n_in [*4];
  endsequence
  a_sleep_stops: assert property (s_sleep_read |-> ##[1:2] !processor_clock_stop_n_out)
    else $error("clock stop not asserted");
  a_sleep_zero: assert property (s_sleep_read |-> prdata_out == 32'h0 && !pslverr_out)
    else $error("sleep port read not zero");
  a_usb_sci: assert property (usb_resume_in && sci_m_ff[9] && !wr_done
    |-> ##[1:2] sci_out)
    else $error("usb event raised no sci");
  a_ring_sci: assert property (s_ring_held ##0 sci_m_ff[8] |-> ##[1:2] sci_out)
    else $error("ring event raised no sci");
  a_ext_smi: assert property ($changed(ext_event_pin_n_in[0]) && smi_m_ff[0]
    |-> ##[1:5] smi_out)
    else $error("pin edge raised no smi");
  a_sci_quiet: assert property (sci_m_ff == 10'h000 && !wr_done |=> !sci_out)
    else $error("sci without mask");
  a_smi_quiet: assert property (smi_m_ff == 10'h000 && !wr_done |=> !smi_out)
    else $error("smi without mask");
  a_power_quiet: assert property (wctl_ff == 11'h000 && !wr_done |=> !main_power_on_out)
    else $error("power on without enable");
  a_ring_power: assert property (s_ring_held ##0 wctl_ff[10] |-> ##[1:2] main_power_on_out)
    else $error("ring gave no power on");
  a_button_power: assert property (s_button_held ##0 wctl_ff[9]
    |-> ##[1:2] main_power_on_out)
    else $error("button gave no power on");
  a_alarm_power: assert property (rtc_alarm_in && wctl_ff[8]
    |-> ##[1:2] main_power_on_out)
    else $error("alarm gave no power on");
  a_ext0_power: assert property ($changed(ext_event_pin_n_in[0]) && wctl_ff[0]
    |-> ##[1:5] main_power_on_out)
    else $error("pin 0 gave no power on");
endmodule
bind pmesw_top pmesw_sva u_sva (.*);

// >>> verification/pmesw_wake_src.sv
/* Model of the wake sources: event pins, ring line, button, alarm, USB.
   Assumes the bench sets wanted levels just after a rising edge. */
`timescale 1ns/100ps
module pmesw_wake_src (
  input  wire logic       mclk_in,
  input  wire logic [7:0] ext_lvl_in,
  input  wire logic       ring_in,
  input  wire logic       button_in,
  input  wire logic       alarm_in,
  input  wire logic       usb_in,
  output logic      [7:0] ext_pin_n_out = 8'hFF,
  output logic            ring_n_out = 1'b1,
  output logic            button_n_out = 1'b1,
  output logic            alarm_out = 1'b0,
  output logic            usb_out = 1'b0
);
  // ****************************************************************
  // Pins follow requests one edge late, unrelated to any bus access
  // ****************************************************************
  always @(posedge mclk_in) begin
    ext_pin_n_out <= ext_lvl_in;
    ring_n_out    <= ~ring_in;
    button_n_out  <= ~button_in;
    alarm_out     <= alarm_in;
    usb_out       <= usb_in;
  end
endmodule

// >>> verification/pmesw_top_tb.sv
/* Self-checking bench for the event, status and wake block.
   Assumes the checker is bound and the wake source model drives pins. */
`timescale 1ns/100ps
module pmesw_top_tb;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  ext_lvl = 8'hFF;
  logic        ring = 1'b0;
  logic        btn = 1'b0;
  logic        alm = 1'b0;
  logic        usb = 1'b0;
  logic [31:0] rd;
  logic        err;
  int          miscompares = 0;
  int          num_checks = 0;
  int          cyc = 0;
  wire  [31:0] prdata;
  wire  [7:0]  ext_n;
  wire         ring_n, btn_n, alm_p, usb_p, pready, pslverr, sci, smi, pwr, stop_n, irq;
  // ****************************************************************
  // Instances and clock
  // ****************************************************************
  pmesw_wake_src SRC (.mclk_in(mclk), .ext_lvl_in(ext_lvl), .ring_in(ring), .button_in(btn),
    .alarm_in(alm), .usb_in(usb), .ext_pin_n_out(ext_n), .ring_n_out(ring_n),
    .button_n_out(btn_n), .alarm_out(alm_p), .usb_out(usb_p));
  pmesw_top DUT (.mclk_in(mclk), .rst_in(rst), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .usb_resume_in(usb_p),
    .ring_indicator_n_in(ring_n), .ext_event_pin_n_in(ext_n), .power_button_n_in(btn_n),
    .rtc_alarm_in(alm_p), .sci_out(sci), .smi_out(smi), .main_power_on_out(pwr),
    .processor_clock_stop_n_out(stop_n), .irq_out(irq));
  always #10 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      give_verdict();
    end
  end
  // ****************************************************************
  // Bus and compare tasks
  // ****************************************************************
  task give_verdict;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task wait_n(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  task drive(input int k, input logic v);
    case (k)
      0: ring <= v;
      1: btn <= v;
      2: alm <= v;
      default: ext_lvl[0] <= ~v;
    endcase
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task t_reset;
    logic [7:0] adr [5];
    adr = '{8'h80, 8'h88, 8'h90, 8'h98, 8'hC0};
    foreach (adr[i]) rdc(adr[i], 32'h0);
    rdc(8'h54, 32'h0);
    wait_n(2);
    chk1(stop_n, 1'b0);
    rdc(8'hC0, 32'h100);
    apb(1'b1, 8'h54, 32'hFFFF_FFFF);
    rdc(8'h54, 32'h0);
    apb(1'b0, 8'h60, 32'h0);
    chk1(err, 1'b1);
  endtask
  task t_usb;
    apb(1'b1, 8'h88, 32'h200);
    rdc(8'hC4, 32'h2);
    apb(1'b1, 8'hC8, 32'h1);
    @(posedge mclk) usb <= 1'b1;
    @(posedge mclk) usb <= 1'b0;
    wait_n(3);
    chk1(sci, 1'b1);
    chk1(smi, 1'b0);
    chk1(stop_n, 1'b1);
    chk1(irq, 1'b1);
    rdc(8'h80, 32'h200);
    apb(1'b1, 8'h80, 32'h0);
    rdc(8'h80, 32'h200);
    apb(1'b1, 8'h80, 32'h200);
    rdc(8'h80, 32'h0);
    chk1(sci, 1'b0);
    rdc(8'hC4, 32'h1);
    wait_n(2);
    chk1(irq, 1'b0);
  endtask
  task t_ext;
    apb(1'b1, 8'h90, 32'hFF);
    for (int i = 0; i < 8; i++) begin
      for (int e = 0; e < 2; e++) begin
        @(posedge mclk) ext_lvl[i] <= ~ext_lvl[i];
        wait_n(5);
        chk1(smi, 1'b1);
        chk1(sci, 1'b0);
        rdc(8'h80, 32'h1 << i);
        apb(1'b1, 8'h80, 32'h1 << i);
      end
    end
    rdc(8'h80, 32'h0);
  endtask
  task t_mask;
    apb(1'b1, 8'h88, 32'hFFFF_FFFF);
    rdc(8'h88, 32'h3FF);
    apb(1'b1, 8'h98, 32'hFFFF_FFFF);
    rdc(8'h98, 32'h701);
    chk1(pwr, 1'b0);
  endtask
  task t_power;
    logic [31:0] ctl [4];
    logic [7:0]  fa [4];
    logic [31:0] fv [4];
    ctl = '{32'h400, 32'h200, 32'h100, 32'h1};
    fa = '{8'h80, 8'hC0, 8'hC0, 8'h80};
    fv = '{32'h100, 32'h1, 32'h2, 32'h1};
    for (int k = 0; k < 4; k++) begin
      apb(1'b1, 8'h98, ctl[k]);
      @(posedge mclk) drive(k, 1'b1);
      wait_n(6);
      chk1(pwr, 1'b1);
      rdc(fa[k], fv[k]);
      @(posedge mclk) drive(k, 1'b0);
      wait_n(5);
      apb(1'b1, fa[k], fv[k]);
      wait_n(2);
      chk1(pwr, 1'b0);
    end
    rdc(8'hC4, 32'h5);
  endtask
  initial begin
    repeat (6) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_usb();
    t_ext();
    t_mask();
    t_power();
    give_verdict();
  end
endmodule
